// >>> common/drive_regs_defines.svh
`ifndef DRIVE_REGS_DEFINES_SVH
`define DRIVE_REGS_DEFINES_SVH
// register offsets (byte addresses on the drive control bus)
`define OFF_ERROR_ONE      6'h08
`define OFF_MAINT          6'h0c
`define OFF_ATTN           6'h10
`define OFF_DBUF           6'h14
`define OFF_DTYPE          6'h18
`define OFF_ROTPOS         6'h1c
`define OFF_ERROR_TWO      6'h20
`define OFF_OFFSET         6'h24
`define OFF_TARGET         6'h28
`define OFF_PRESENT        6'h2c
`define OFF_SERIAL         6'h30
// error_one bit positions
`define E1_FORMAT          4
`define E1_PARITY          3
`define E1_REFUSED         2
`define E1_BADREG          1
`define E1_BADFUNC         0
`define E1_LOW_MASK        5'h1f
// error_two bit positions and writable mask
`define E2_MAINS           15
`define E2_LOCK            13
`define E2_VOLT30          12
`define E2_INDEX           11
`define E2_NOHEAD          10
`define E2_MASK            16'hbc00
// head_offset_control fields
`define OF_FMT             12
`define OF_MASK            16'h9cff
// drive type fixed upper bits: moving head set
`define DTYPE_FIXED        4'h2
`define DTYPE_DUAL         11
// cylinder field width
`define CYL_W              10
`define CYL_MASK           16'h03ff
// diagnostic buffer depth
`define DBUF_DEPTH         8
`endif

// >>> common/drive_regs_pkg.sv
package drive_regs_pkg;
   // access phase of the register port
   typedef enum logic [2:0] {
      ACC_IDLE  = 3'b001,
      ACC_READ  = 3'b010,
      ACC_WRITE = 3'b100
   } acc_state_t;
endpackage : drive_regs_pkg

// >>> common/dbuf_if.sv
`timescale 1ns/100ps
// push/pop channel between register port and diagnostic buffer
interface dbuf_if;
   logic        push;
   logic        pop;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        in_ready;
   logic        out_ready;
   modport owner (input push, pop, wdata, output rdata, in_ready, out_ready);
   modport user  (output push, pop, wdata, input rdata, in_ready, out_ready);
endinterface : dbuf_if

// >>> rtl/diag_word_buffer.sv
`timescale 1ns/100ps
`include "drive_regs_defines.svh"
// eight-word first-in first-out diagnostic store
module diag_word_buffer #(
   parameter int DEPTH = `DBUF_DEPTH
) (
   input  wire logic core_clk,
   input  wire logic srst,
   dbuf_if.owner     bus
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } buf_state_t;
   buf_state_t  s_q;
   buf_state_t  s_d;
   logic [15:0] mem [DEPTH];

   ////////////////////////////////////////////////////////////////////////
   // pointer update; push and pop gated by their ready flags
   always_comb begin
      s_d = s_q;
      if (bus.push && bus.in_ready) begin
         s_d.wp = s_q.wp + 1'b1;
      end
      if (bus.pop && bus.out_ready) begin
         s_d.rp = s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(bus.push && bus.in_ready)
                        - (AW+1)'(bus.pop && bus.out_ready);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // storage array, no reset needed for data
   always_ff @(posedge core_clk) begin
      if (bus.push && bus.in_ready) begin
         mem[s_q.wp] <= bus.wdata;
      end
   end

   assign bus.rdata     = mem[s_q.rp];
   assign bus.in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
   assign bus.out_ready = (s_q.cnt != '0);
endmodule : diag_word_buffer

// >>> rtl/rotational_tracker.sv
`timescale 1ns/100ps
`include "drive_regs_defines.svh"
// derives sector number and fifth-of-sector from index/sector/fifth pulses
module rotational_tracker #(
   parameter int SECTORS = 22
) (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        index_pulse,
   input  wire logic        sector_pulse,
   input  wire logic        fifth_pulse,
   output logic      [6:0]  position
);
   typedef struct packed {
      logic [4:0] sector;
      logic [2:0] fifth;
   } trk_state_t;
   trk_state_t s_q;
   trk_state_t s_d;

   ////////////////////////////////////////////////////////////////////////
   // index restarts the count, sector pulse advances it
   always_comb begin
      s_d = s_q;
      if (index_pulse) begin
         s_d = '0;
      end else if (sector_pulse) begin
         s_d.sector = (s_q.sector == 5'(SECTORS - 1)) ? '0
                                                     : s_q.sector + 1'b1;
         s_d.fifth  = '0;
      end else if (fifth_pulse && s_q.fifth != 3'h4) begin
         s_d.fifth = s_q.fifth + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // code 3 means past four fifths, so count 3 still reports code 2
   always_comb begin
      position[6:2] = s_q.sector;
      case (s_q.fifth)
         3'h0:    position[1:0] = 2'h0;
         3'h1:    position[1:0] = 2'h1;
         3'h2:    position[1:0] = 2'h2;
         3'h3:    position[1:0] = 2'h2;
         default: position[1:0] = 2'h3;
      endcase
   end
endmodule : rotational_tracker

// >>> rtl/disk_drive_register_file.sv
`timescale 1ns/100ps
`include "drive_regs_defines.svh"
// Summary of operation
// - set format mismatch when header format differs from offset bit 12
// - any error bit sets summary; cleared by zero write, fault reset, init
// - set parity fault on write-transfer data or register-write parity
// - writes while go is set are refused, except attention summary
// - access to a nonexistent register sets bad register bit
// - undefined function code written sets bad function bit
// - attention summary bits 7-0 latch each drive's attention flag
// - attention bits clear on write of one, flag clear, or init
// - rotational position bits 10-6 give current sector number
// - bits 5-4 give the fifth of the sector under the heads
// - diagnostic buffer holds eight words, gated by ready flags
// - drive type high bits read fixed: only moving head is one
// - drive type bit 11 shows dual-ported drive
// - drive type bits 8-0 carry a fixed model code
// - serial register returns four low serial digits in bcd
// - offset bits 7-0 distance; bits 11, 10 inhibit ecc and header
// - target cylinder bits 9-0 hold positioning target
// - present cylinder bits 9-0 report where heads sit
// - error two flags mains loss, lock loss, 30 volt loss
// - error two flags index error and no head selected
// - while summary set, only fault reset commands are accepted
module disk_drive_register_file #(
   parameter logic [8:0]  MODEL_CODE = 9'h0_0a5, // arbitrary value
   parameter logic [15:0] SERIAL_BCD = 16'h1_234 // arbitrary value
) (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        bus_init,
   input  wire logic        ctrl_req,
   input  wire logic        ctrl_write,
   input  wire logic [5:0]  ctrl_addr,
   input  wire logic [15:0] ctrl_wdata,
   input  wire logic        ctrl_par_err,
   output logic      [15:0] ctrl_rdata,
   output logic             ctrl_ack,
   input  wire logic        func_write,
   input  wire logic        func_valid,
   input  wire logic        func_fault_reset,
   input  wire logic        adapter_reset,
   input  wire logic        go_busy,
   input  wire logic        xfer_write,
   input  wire logic        data_par_err,
   input  wire logic        hdr_valid,
   input  wire logic        hdr_fmt18,
   input  wire logic        mains_loss,
   input  wire logic        lock_loss,
   input  wire logic        volt30_loss,
   input  wire logic        index_bad,
   input  wire logic        nohead_cmd,
   input  wire logic        dual_ported,
   input  wire logic [7:0]  drive_attn,
   input  wire logic [7:0]  drive_attn_clr,
   input  wire logic        index_pulse,
   input  wire logic        sector_pulse,
   input  wire logic        fifth_pulse,
   input  wire logic [9:0]  heads_cyl,
   input  wire logic        heads_moving,
   output logic             error_summary,
   output logic             attn_out,
   output logic             cmd_reject,
   output logic      [15:0] offset_ctl,
   output logic      [9:0]  target_cyl,
   output logic      [15:0] maint_ctl,
   output logic             dbuf_in_ready,
   output logic             dbuf_out_ready
);
   typedef struct packed {
      drive_regs_pkg::acc_state_t st;
      logic [15:0] rdata;
      logic        ack;
      logic [4:0]  err1;
      logic [15:0] err2;
      logic [7:0]  attn;
      logic [15:0] offs;
      logic [9:0]  tcyl;
      logic [9:0]  pcyl;
      logic [15:0] maint;
      logic        summ;
      logic        rej;
      logic        ir;
      logic        orr;
   } rf_state_t;

   rf_state_t   s_q;
   rf_state_t   s_d;
   logic [6:0]  rot_pos;
   logic [15:0] dtype;
   logic        addr_ok;
   logic        clr_all;
   logic        wr_ok;
   logic [4:0]  e1_set;
   logic [15:0] e2_set;

   dbuf_if dbuf ();

   ////////////////////////////////////////////////////////////////////////
   // leaves
   diag_word_buffer #(.DEPTH(`DBUF_DEPTH)) u_dbuf (
      .core_clk (core_clk),
      .srst     (srst),
      .bus      (dbuf)
   );

   rotational_tracker u_rot (
      .core_clk     (core_clk),
      .srst         (srst),
      .index_pulse  (index_pulse),
      .sector_pulse (sector_pulse),
      .fifth_pulse  (fifth_pulse),
      .position     (rot_pos)
   );

   ////////////////////////////////////////////////////////////////////////
   // decode and event sources
   always_comb begin
      case (ctrl_addr)
         `OFF_ERROR_ONE, `OFF_MAINT, `OFF_ATTN, `OFF_DBUF, `OFF_DTYPE,
         `OFF_ROTPOS, `OFF_ERROR_TWO, `OFF_OFFSET, `OFF_TARGET,
         `OFF_PRESENT, `OFF_SERIAL: addr_ok = 1'b1;
         default:                   addr_ok = 1'b0;
      endcase
   end

   // drive clear paths share one term
   assign clr_all = bus_init || adapter_reset
                 || (func_write && func_fault_reset);
   // a write is taken only when idle-or-attention and parity clean
   assign wr_ok   = ctrl_req && ctrl_write && addr_ok && !ctrl_par_err
                 && (!go_busy || ctrl_addr == `OFF_ATTN);

   // drive type word; high nibble fixed, model code per unit
   assign dtype = {`DTYPE_FIXED, dual_ported, 2'b00,
                   MODEL_CODE};

   always_comb begin
      e1_set = '0;
      e1_set[`E1_FORMAT]  = hdr_valid
                         && (hdr_fmt18 != s_q.offs[`OF_FMT]);
      e1_set[`E1_PARITY]  = (xfer_write && data_par_err)
                         || (ctrl_req && ctrl_write && ctrl_par_err);
      e1_set[`E1_REFUSED] = ctrl_req && ctrl_write && go_busy
                         && ctrl_addr != `OFF_ATTN;
      e1_set[`E1_BADREG]  = ctrl_req && !addr_ok;
      // bad function set only by an undefined function code; refused commands do not land here
      e1_set[`E1_BADFUNC] = func_write && !func_valid;
      e2_set = '0;
      e2_set[`E2_MAINS]   = mains_loss;
      e2_set[`E2_LOCK]    = lock_loss;
      e2_set[`E2_VOLT30]  = volt30_loss;
      e2_set[`E2_INDEX]   = index_bad;
      e2_set[`E2_NOHEAD]  = nohead_cmd;
   end

   // condition levels come from drive logic on core_clk: no synchroniser,
   // so a one-cycle condition is never lost or delayed

   ////////////////////////////////////////////////////////////////////////
   // next-state: register access, sticky errors, attention, mirrors
   always_comb begin
      s_d       = s_q;
      s_d.ack   = 1'b0;
      s_d.ir    = dbuf.in_ready;
      s_d.orr   = dbuf.out_ready;
      dbuf.push = 1'b0;
      dbuf.pop  = 1'b0;
      dbuf.wdata = ctrl_wdata;

      // one access per request pulse
      case (s_q.st)
         drive_regs_pkg::ACC_IDLE: begin
            if (ctrl_req) begin
               s_d.st = ctrl_write ? drive_regs_pkg::ACC_WRITE
                                   : drive_regs_pkg::ACC_READ;
            end
         end
         default: s_d.st = drive_regs_pkg::ACC_IDLE;
      endcase

      // read mux; answer the cycle after the request
      if (ctrl_req && !ctrl_write) begin
         s_d.ack = 1'b1;
         case (ctrl_addr)
            `OFF_ERROR_ONE: s_d.rdata = {11'h0, s_q.err1};
            `OFF_ERROR_TWO: s_d.rdata = s_q.err2;
            `OFF_ATTN:      s_d.rdata = {8'h0, s_q.attn};
            `OFF_ROTPOS:    s_d.rdata = {5'h0, rot_pos, 4'h0};
            `OFF_DBUF: begin
               s_d.rdata = dbuf.out_ready ? dbuf.rdata : 16'h0;
               dbuf.pop  = 1'b1;
            end
            `OFF_MAINT:     s_d.rdata = s_q.maint;
            `OFF_DTYPE:     s_d.rdata = dtype;
            `OFF_SERIAL:    s_d.rdata = SERIAL_BCD;
            `OFF_OFFSET:    s_d.rdata = s_q.offs;
            `OFF_TARGET:    s_d.rdata = {6'h0, s_q.tcyl};
            `OFF_PRESENT:   s_d.rdata = {6'h0, s_q.pcyl};
            default:        s_d.rdata = 16'h0;
         endcase
      end else if (ctrl_req) begin
         s_d.ack = 1'b1;
      end

      // writes; unused bits masked away
      if (wr_ok) begin
         case (ctrl_addr)
            `OFF_ERROR_ONE: s_d.err1 = s_q.err1 & ctrl_wdata[4:0];
            `OFF_ERROR_TWO: s_d.err2 = s_q.err2 & ctrl_wdata & `E2_MASK;
            `OFF_ATTN:      s_d.attn = s_q.attn & ~ctrl_wdata[7:0];
            `OFF_OFFSET:    s_d.offs = ctrl_wdata & `OF_MASK;
            `OFF_TARGET:    s_d.tcyl = ctrl_wdata[`CYL_W-1:0];
            `OFF_MAINT:     s_d.maint = ctrl_wdata;
            `OFF_DBUF:      dbuf.push = 1'b1;
            default: ;
         endcase
      end

      // attention: drive flag clear drops the bit, a raise sets it;
      // a raise in the same cycle as a clear wins
      s_d.attn = (s_d.attn & ~drive_attn_clr) | drive_attn;

      // present cylinder tracks heads only while stationary
      if (!heads_moving) begin
         s_d.pcyl = heads_cyl;
      end

      // clearing events, then sticky sets so a set wins over a clear
      if (clr_all) begin
         s_d.err1 = '0;
         s_d.err2 = '0;
      end
      if (bus_init) begin
         s_d.attn  = '0;
         s_d.offs  = '0;
         s_d.tcyl  = '0;
         s_d.maint = '0;
      end
      s_d.err1 = s_d.err1 | e1_set;
      s_d.err2 = s_d.err2 | e2_set;

      // summary follows the error registers
      s_d.summ = (|s_d.err1) || (|s_d.err2);
      // commands other than fault reset are refused while summary set
      s_d.rej  = s_q.summ && func_write && !func_fault_reset;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_q    <= '0;
         s_q.st <= drive_regs_pkg::ACC_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops
   assign ctrl_rdata     = s_q.rdata;
   assign ctrl_ack       = s_q.ack;
   assign error_summary  = s_q.summ;
   assign attn_out       = s_q.summ;
   assign cmd_reject     = s_q.rej;
   assign offset_ctl     = s_q.offs;
   assign target_cyl     = s_q.tcyl;
   assign maint_ctl      = s_q.maint;
   assign dbuf_in_ready  = s_q.ir;
   assign dbuf_out_ready = s_q.orr;
endmodule : disk_drive_register_file

// >>> test/drive_regs_checker_sva.sv
`timescale 1ns/100ps
`include "drive_regs_defines.svh"
// port-level checks of the register file access and error rules
module drive_regs_checker (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        bus_init,
   input  wire logic        ctrl_req,
   input  wire logic        ctrl_write,
   input  wire logic [5:0]  ctrl_addr,
   input  wire logic [15:0] ctrl_wdata,
   input  wire logic        ctrl_par_err,
   input  wire logic        ctrl_ack,
   input  wire logic        go_busy,
   input  wire logic        func_write,
   input  wire logic        func_valid,
   input  wire logic        func_fault_reset,
   input  wire logic        error_summary,
   input  wire logic        attn_out,
   input  wire logic        cmd_reject,
   input  wire logic [15:0] offset_ctl,
   input  wire logic [9:0]  target_cyl
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////
   // target write taken only when idle and parity clean
   logic tgt_wr;
   assign tgt_wr = ctrl_req && ctrl_write && ctrl_addr == `OFF_TARGET;
   // every request gets its answer one cycle later, and only then
   property p_ack; ctrl_req |=> ctrl_ack; endproperty
   a_ack: assert property (p_ack) else $error("answer missing");
   property p_noack; !ctrl_req |=> !ctrl_ack; endproperty
   a_noack: assert property (p_noack) else $error("stray answer");
   // an undefined function raises summary and attention the next cycle
   property p_attn; func_write && !func_valid |=> attn_out && error_summary;
   endproperty
   a_attn: assert property (p_attn) else $error("attention differs");
   // target writes during a running operation leave the register alone
   property p_refuse; tgt_wr && go_busy && !bus_init |=> $stable(target_cyl);
   endproperty
   a_refuse: assert property (p_refuse) else $error("busy write taken");
   property p_tgt;
      tgt_wr && !go_busy && !ctrl_par_err && !bus_init
         |=> target_cyl == $past(ctrl_wdata[9:0]);
   endproperty
   a_tgt: assert property (p_tgt) else $error("target not written");
   // a bad register address forces the summary on the next cycle
   property p_badreg; ctrl_req && ctrl_addr == 6'h34 |=> error_summary;
   endproperty
   a_badreg: assert property (p_badreg) else $error("no summary");
   // unused offset bits never show
   property p_ofmask; (offset_ctl & ~`OF_MASK) == 16'h0000; endproperty
   a_ofmask: assert property (p_ofmask) else $error("offset unused set");
   // ordinary commands are rejected while the summary is set
   property p_reject;
      func_write && func_valid && !func_fault_reset && error_summary
         |-> ##[1:2] cmd_reject;
   endproperty
   a_reject: assert property (p_reject) else $error("no reject");
   property p_init; bus_init |=> offset_ctl == 16'h0000 && target_cyl == 0;
   endproperty
   a_init: assert property (p_init) else $error("init kept value");
   c_refuse: cover property (tgt_wr && go_busy);
   c_reject: cover property (cmd_reject);
   c_badreg: cover property (ctrl_req && ctrl_addr == 6'h34);
endmodule : drive_regs_checker

bind disk_drive_register_file drive_regs_checker u_chk (.core_clk, .srst,
   .bus_init, .ctrl_req, .ctrl_write, .ctrl_addr, .ctrl_wdata, .ctrl_par_err,
   .ctrl_ack, .go_busy, .func_write, .func_valid, .func_fault_reset,
   .error_summary, .attn_out, .cmd_reject, .offset_ctl, .target_cyl);

// >>> test/ctrl_adapter_model.sv
`timescale 1ns/100ps
// controller adapter side of the drive control bus
module ctrl_adapter_model (
   input  wire logic        core_clk,
   input  wire logic        ctrl_ack,
   input  wire logic [15:0] ctrl_rdata,
   output logic             ctrl_req,
   output logic             ctrl_write,
   output logic      [5:0]  ctrl_addr,
   output logic      [15:0] ctrl_wdata,
   output logic             ctrl_par_err
);
   logic ctrl_par_flag; // adapter's own control parity flag
   initial begin
      {ctrl_req, ctrl_write, ctrl_addr, ctrl_wdata, ctrl_par_err} = '0;
      ctrl_par_flag = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // one access: request for a cycle, answer taken at the next falling edge
   task automatic acc(input logic w, input logic [5:0] a,
                      input logic [15:0] d, input logic p,
                      output logic [15:0] q);
      @(negedge core_clk);
      {ctrl_req, ctrl_write, ctrl_addr, ctrl_wdata, ctrl_par_err} =
         {1'b1, w, a, d, p};
      @(negedge core_clk);
      q = ctrl_ack ? ctrl_rdata : 16'hxxxx;
      if (p && !w)
         ctrl_par_flag = 1'b1;
      // released address and data lines show the inverse so stale values never pass
      {ctrl_req, ctrl_addr, ctrl_wdata, ctrl_par_err} = {1'b0, ~a, ~d, 1'b0};
   endtask : acc
endmodule : ctrl_adapter_model

// >>> test/disk_drive_register_file_tb.sv
`timescale 1ns/100ps
`include "drive_regs_defines.svh"
module disk_drive_register_file_tb;
   localparam logic [8:0]  MODEL = 9'h05a;   // arbitrary value
   localparam logic [15:0] SER   = 16'h4321; // arbitrary value
   logic core_clk, srst, bus_init, func_write, func_valid, func_fault_reset;
   logic adapter_reset, go_busy, xfer_write, data_par_err, hdr_valid;
   logic hdr_fmt18, mains_loss, lock_loss, volt30_loss, index_bad;
   logic nohead_cmd, dual_ported, heads_moving, index_pulse, sector_pulse;
   logic fifth_pulse, ctrl_req, ctrl_write, ctrl_par_err, ctrl_ack;
   logic error_summary, attn_out, cmd_reject, in_rdy, out_rdy;
   logic [7:0]  drive_attn, drive_attn_clr;
   logic [9:0]  heads_cyl, target_cyl;
   logic [5:0]  ctrl_addr;
   logic [15:0] ctrl_wdata, ctrl_rdata, offset_ctl, maint_ctl, rd;
   logic [15:0] e2_exp [5] = '{16'h8000, 16'h2000, 16'h1000, 16'h0800,
                               16'h0400};
   int          miscompares, n_compared;
   disk_drive_register_file #(.MODEL_CODE(MODEL), .SERIAL_BCD(SER)) DUT (
      .core_clk, .srst, .bus_init, .ctrl_req, .ctrl_write, .ctrl_addr,
      .ctrl_wdata, .ctrl_par_err, .ctrl_rdata, .ctrl_ack, .func_write,
      .func_valid, .func_fault_reset, .adapter_reset, .go_busy, .xfer_write,
      .data_par_err, .hdr_valid, .hdr_fmt18, .mains_loss, .lock_loss,
      .volt30_loss, .index_bad, .nohead_cmd, .dual_ported, .drive_attn,
      .drive_attn_clr, .index_pulse, .sector_pulse, .fifth_pulse,
      .heads_cyl, .heads_moving, .error_summary, .attn_out, .cmd_reject,
      .offset_ctl, .target_cyl, .maint_ctl, .dbuf_in_ready(in_rdy),
      .dbuf_out_ready(out_rdy));
   ctrl_adapter_model u_adp (.core_clk, .ctrl_ack, .ctrl_rdata, .ctrl_req,
      .ctrl_write, .ctrl_addr, .ctrl_wdata, .ctrl_par_err);
   ////////////////////////////////////////////////////////////////////////
   // shared compare, access and pulse helpers
   task automatic chk(input string what, input logic [15:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      u_adp.acc(1'b1, a, d, 1'b0, rd);
   endtask : wr
   task automatic rdc(input string what, input logic [5:0] a,
                      input logic [15:0] exp);
      u_adp.acc(1'b0, a, 16'h0000, 1'b0, rd);
      chk(what, exp, rd);
   endtask : rdc
   task automatic pls(ref logic s);
      @(negedge core_clk);
      s = 1'b1;
      @(negedge core_clk);
      s = 1'b0;
   endtask : pls
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////
   // clock, and a watchdog well beyond the few hundred cycles needed
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      end_sim();
   end
   // main sequence: inputs change only at falling edges
   initial begin
      {bus_init, func_write, func_valid, func_fault_reset, adapter_reset,
       go_busy, xfer_write, data_par_err, hdr_valid, hdr_fmt18, mains_loss,
       lock_loss, volt30_loss, index_bad, nohead_cmd, dual_ported,
       heads_moving, index_pulse, sector_pulse, fifth_pulse, drive_attn,
       drive_attn_clr, heads_cyl} = '0;
      srst = 1'b1;
      repeat (5) @(negedge core_clk);
      srst = 1'b0;
      rdc("error_one", `OFF_ERROR_ONE, 16'h0000);
      rdc("dtype", `OFF_DTYPE, {4'h2, 3'b000, MODEL});
      dual_ported = 1'b1;
      rdc("dtype", `OFF_DTYPE, {4'h2, 3'b100, MODEL});
      rdc("serial", `OFF_SERIAL, SER);
      wr(`OFF_OFFSET, 16'hffff);
      rdc("offset", `OFF_OFFSET, 16'h9cff);
      chk("offset_ctl", 16'h9cff, offset_ctl);
      wr(`OFF_OFFSET, 16'h0000);
      wr(`OFF_TARGET, 16'hffff);
      rdc("target", `OFF_TARGET, 16'h03ff);
      chk("target_cyl", 16'h03ff, {6'h00, target_cyl});
      heads_cyl = 10'h32a;
      rdc("present", `OFF_PRESENT, 16'h032a);
      {heads_moving, heads_cyl} = {1'b1, 10'h111};
      rdc("present", `OFF_PRESENT, 16'h032a);
      heads_moving = 1'b0;
      wr(`OFF_MAINT, 16'h5a3c);
      rdc("maint", `OFF_MAINT, 16'h5a3c);
      chk("maint_ctl", 16'h5a3c, maint_ctl);
      // nonexistent register, then a zero write clears it
      rdc("badreg", 6'h34, 16'h0000);
      rdc("error_one", `OFF_ERROR_ONE, 16'h0002);
      chk("summary", 16'h0001, {15'h0000, error_summary});
      wr(`OFF_ERROR_ONE, 16'h0000);
      rdc("error_one", `OFF_ERROR_ONE, 16'h0000);
      chk("summary", 16'h0000, {15'h0000, error_summary});
      // write while go is set is refused; fault reset clears
      go_busy = 1'b1;
      wr(`OFF_TARGET, 16'h0123);
      go_busy = 1'b0;
      rdc("target", `OFF_TARGET, 16'h03ff);
      rdc("error_one", `OFF_ERROR_ONE, 16'h0004);
      {func_valid, func_fault_reset} = 2'b11;
      pls(func_write);
      rdc("error_one", `OFF_ERROR_ONE, 16'h0000);
      // parity on register write, then adapter reset clears
      u_adp.acc(1'b1, `OFF_TARGET, 16'h0001, 1'b1, rd);
      rdc("target", `OFF_TARGET, 16'h03ff);
      rdc("error_one", `OFF_ERROR_ONE, 16'h0008);
      pls(adapter_reset);
      rdc("error_one", `OFF_ERROR_ONE, 16'h0000);
      xfer_write = 1'b1;
      pls(data_par_err);
      xfer_write = 1'b0;
      rdc("error_one", `OFF_ERROR_ONE, 16'h0008);
      pls(bus_init);
      // read-side parity belongs to the adapter, not the drive
      pls(data_par_err);
      u_adp.acc(1'b0, `OFF_TARGET, 16'h0000, 1'b1, rd);
      chk("adp_par", 16'h0001, {15'h0000, u_adp.ctrl_par_flag});
      rdc("error_one", `OFF_ERROR_ONE, 16'h0000);
      // undefined function, then an ordinary command is rejected
      {func_valid, func_fault_reset} = 2'b00;
      pls(func_write);
      rdc("error_one", `OFF_ERROR_ONE, 16'h0001);
      func_valid = 1'b1;
      pls(func_write);
      chk("reject", 16'h0001, {15'h0000, cmd_reject});
      chk("attn", 16'h0001, {15'h0000, attn_out});
      wr(`OFF_ERROR_ONE, 16'h0000);
      // header format against offset bit 12
      hdr_fmt18 = 1'b1;
      pls(hdr_valid);
      rdc("error_one", `OFF_ERROR_ONE, 16'h0010);
      wr(`OFF_OFFSET, 16'h1000);
      wr(`OFF_ERROR_ONE, 16'h0000);
      pls(hdr_valid);
      rdc("error_one", `OFF_ERROR_ONE, 16'h0000);
      // each error_two source in turn
      for (int i = 0; i < 5; i++) begin
         @(negedge core_clk);
         {mains_loss, lock_loss, volt30_loss, index_bad, nohead_cmd} =
            5'h10 >> i;
         @(negedge core_clk);
         {mains_loss, lock_loss, volt30_loss, index_bad, nohead_cmd} = '0;
         rdc("error_two", `OFF_ERROR_TWO, e2_exp[i]);
         wr(`OFF_ERROR_TWO, 16'h0000);
      end
      rdc("error_two", `OFF_ERROR_TWO, 16'h0000);
      // attention summary: set, write-one clear while busy, flag clear
      @(negedge core_clk);
      drive_attn = 8'ha5;
      @(negedge core_clk);
      drive_attn = 8'h00;
      rdc("attn_sum", `OFF_ATTN, 16'h00a5);
      go_busy = 1'b1;
      wr(`OFF_ATTN, 16'hff05);
      go_busy = 1'b0;
      rdc("attn_sum", `OFF_ATTN, 16'h00a0);
      @(negedge core_clk);
      drive_attn_clr = 8'h80;
      @(negedge core_clk);
      drive_attn_clr = 8'h00;
      rdc("attn_sum", `OFF_ATTN, 16'h0020);
      pls(bus_init);
      rdc("attn_sum", `OFF_ATTN, 16'h0000);
      // sector three, fourth fifth pulse gives the last code
      pls(index_pulse);
      repeat (3) pls(sector_pulse);
      repeat (4) pls(fifth_pulse);
      rdc("rotpos", `OFF_ROTPOS, 16'h00f0);
      // diagnostic buffer: fill eight, read back in order
      chk("in_rdy", 16'h0001, {15'h0000, in_rdy});
      for (int i = 0; i < 8; i++)
         wr(`OFF_DBUF, 16'hd000 + 16'(i));
      repeat (2) @(negedge core_clk);
      chk("in_rdy", 16'h0000, {15'h0000, in_rdy});
      chk("out_rdy", 16'h0001, {15'h0000, out_rdy});
      for (int i = 0; i < 8; i++)
         rdc("dbuf", `OFF_DBUF, 16'hd000 + 16'(i));
      repeat (2) @(negedge core_clk);
      chk("out_rdy", 16'h0000, {15'h0000, out_rdy});
      end_sim();
   end
endmodule : disk_drive_register_file_tb
